// ===== rtl/mcis_params.svh
`ifndef MCIS_PARAMS_SVH
`define MCIS_PARAMS_SVH
`define MCIS_CLK_MHZ    200
`define MCIS_FRAME_NS   320000
`define MCIS_FRAME_CYC  ((`MCIS_FRAME_NS * `MCIS_CLK_MHZ + 999) / 1000)
`define MCIS_A_CTRL     12'h000
`define MCIS_A_CYC      12'h004
`define MCIS_A_NS       12'h008
`define MCIS_A_DLY      12'h00C
`define MCIS_A_NL       12'h010
`define MCIS_A_VCC      12'h014
`define MCIS_A_ICC      12'h018
`define MCIS_A_PCC      12'h01C
`define MCIS_A_STAT     12'h020
`define MCIS_A_EACC     12'h040
`define MCIS_A_RES      12'h080
`define MCIS_N_RES      18
`define MCIS_CONN_RST   2'h0
`define MCIS_APP_RST    1'h0
`define MCIS_CYC_RST    8'h01
`define MCIS_NS_RST     16'h003E
`define MCIS_DLY_RST    8'h05
`define MCIS_CC_RST     16'h0001
`define MCIS_NL_SHIFT   8
`define MCIS_PF_SHIFT   14
`define MCIS_FREQ_K     64'h00000000002FAF08
`define MCIS_ANG_K      64'h0000000000008CA0
`define MCIS_DIV_IT     7'h40
`define MCIS_SQRT_IT    7'h20
`endif

// ===== rtl/mcis_pkg.sv
`default_nettype none
package mcis_pkg;
   typedef enum logic [2:0] {
      E_IDLE = 3'b000,
      E_RMS  = 3'b001,
      E_PHS  = 3'b010,
      E_MISC = 3'b011,
      E_DIV  = 3'b100,
      E_SQRT = 3'b101
   } mcis_stage_t;

   typedef struct packed {
      logic [2:0][15:0] v;
      logic [2:0][15:0] i;
      logic [2:0][31:0] q;
      logic [2:0][31:0] raw_rms_voltage;
      logic [2:0][31:0] raw_rms_current;
      logic [1:0][15:0] zc;
   } mcis_afe_t;

   typedef struct packed {
      logic [1:0]        conn;
      logic              apparent_method_select;
      logic [7:0]        cyc;
      logic [15:0]       ns;
      logic [7:0]        dly;
      logic [16:0]       nl;
      logic [15:0]       vcc;
      logic [15:0]       icc;
      logic [15:0]       pcc;
      logic              ovr;
      logic              busy;
      logic              pen;
      logic [15:0]       tick;
      logic [15:0]       fcnt;
      logic [5:0][63:0]  acc;
      logic [5:0][63:0]  snap;
      logic [5:0][31:0]  rms;
      logic [1:0][15:0]  zc;
      logic [2:0][63:0]  eacc;
      logic [17:0][47:0] res;
      mcis_stage_t       st;
      mcis_stage_t       ret;
      logic [2:0]        k;
      logic [1:0]        ph;
      logic              done;
      logic [6:0]        it;
      logic [63:0]       num;
      logic [47:0]       den;
      logic [65:0]       rem;
      logic [31:0]       root;
      logic [47:0]       pavg;
      logic [47:0]       qavg;
      logic [47:0]       sap;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
   } mcis_state_t;
endpackage
`default_nettype wire

// ===== rtl/mcis_top.sv
// What this block does
// - Sum per-phase voltage-current products continuously over the integration period.
// - Frame count reaching samples-per-cycle: snapshot, clear sums, restart, trigger processing.
// - Accumulation runs during processing; a trigger while busy loses data.
// - First phase sums VA*IA, third phase sums VC*IC.
// - Two-bit select picks second-phase product among four forms.
// - Nonzero start delay blocks energy accumulation and disables pulse outputs.
// - Start delay counts down per processing cycle; host nonzero write restarts it.
// - Start delay resets to five processing cycles.
// - Phase below no-load current threshold adds no energy.
// - Zero threshold disables creep check; 0x10000 means full-scale current.
// - Results are eight-byte values with at most 48 significant bits.
// - Conversion constants only rescale; no calibration gain applied here.
// - RMS display value is 32-bit RMS times 16-bit constant, 48 bits.
// - Power is cycle energy times power constant over samples-per-cycle.
// - Power factor is real over apparent power, scaled by 2^14.
// - Line frequency in millihertz from mean samples-per-cycle value.
// - Phasor angles from per-cycle angle counts, in 0.01 degree.
// - Apparent select: 0 uses RMS product, 1 uses root of squares.
// - Samples-per-cycle counts frames, each frame lasting 320 us.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "mcis_params.svh"
`default_nettype none
module mcis_top #(
   parameter int FRAME_CYC = `MCIS_FRAME_CYC
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   input  wire mcis_pkg::mcis_afe_t afe,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic                    pulse_enable,
   output logic                    post_busy
);
   import mcis_pkg::*;

   if (FRAME_CYC < 2 || FRAME_CYC > 65536) begin : g_chk
      $error("FRAME_CYC must be 2..65536");
   end

   localparam logic [15:0] TICK_END = 16'(FRAME_CYC - 1);

   mcis_state_t      x;
   mcis_state_t      n;
   logic signed [16:0] vsum;
   logic signed [16:0] vdif;
   logic [2:0][63:0] prod;
   logic             tk;
   logic             trig;
   logic             ovr_set;
   logic             ld;
   logic             ldsq;
   logic             adv;
   logic [63:0]      lnum;
   logic [47:0]      lden;
   logic [47:0]      q48;
   logic [47:0]      pmag;
   logic [47:0]      qmag;
   logic [47:0]      vi;
   logic [48:0]      dr;
   logic [65:0]      sr;
   logic [65:0]      trial;
   logic             ge;
   logic             acc_ok;
   logic             mapped;
   logic [31:0]      rd;
   logic [11:0]      off;
   logic [63:0]      word;

   function automatic logic [63:0] smul(input logic signed [16:0] a,
                                        input logic signed [16:0] b);
      smul = 64'(a) * 64'(b);
   endfunction

   function automatic logic [47:0] mag(input logic [63:0] a);
      logic [63:0] t;
      t = a[63] ? -a : a;
      mag = (t[63:48] != 16'h0000) ? 48'hFFFFFFFFFFFF : t[47:0];
   endfunction

   always_comb begin
      n       = x;
      vsum    = 17'($signed(afe.v[0])) + 17'($signed(afe.v[2]));
      vdif    = 17'($signed(afe.v[0])) - 17'($signed(afe.v[2]));
      prod[0] = smul($signed(afe.v[0]), $signed(afe.i[0]));
      prod[2] = smul($signed(afe.v[2]), $signed(afe.i[2]));
      unique case (x.conn)
         2'h0: prod[1] = smul($signed(afe.i[1]), $signed(afe.v[1]));
         2'h1: prod[1] = -smul($signed(afe.i[1]), $signed(afe.v[2]));
         2'h2: prod[1] = -smul($signed(afe.i[1]), vsum);
         2'h3: prod[1] = -smul($signed(afe.i[1]), vdif);
      endcase
      trig    = 1'b0;
      ovr_set = 1'b0;
      ld      = 1'b0;
      ldsq    = 1'b0;
      adv     = 1'b0;
      lnum    = 64'h0;
      lden    = 48'h0;
      q48     = (x.num[63:48] != 16'h0000) ? 48'hFFFFFFFFFFFF : x.num[47:0];
      pmag    = mag(x.snap[x.ph]);
      qmag    = mag(x.snap[3'(x.ph) + 3'h3]);
      vi      = {24'h0, x.rms[x.ph][31:8]} * {24'h0, x.rms[3'(x.ph) + 3'h3][31:8]};
      dr      = {x.rem[47:0], x.num[63]};
      ge      = 1'b0;
      sr      = {x.rem[63:0], x.num[63:62]};
      trial   = {32'h0, x.root, 2'b01};
      acc_ok  = 1'b0;

      // one divider/root engine is shared by every division and square-root step;
      // each step runs 64 (or 32) iterations plus a return cycle, far below a frame
      unique case (x.st)
         E_IDLE: ;
         E_RMS: begin
            // conversion constant only rescales, no gain term
            n.res[x.k] = {16'h0, x.rms[x.k]}
                       * {32'h0, (x.k < 3'h3) ? x.vcc : x.icc};
            if (x.k == 3'h5) begin
               n.st = E_PHS;
               n.k  = 3'h0;
            end else begin
               n.k = x.k + 3'h1;
            end
         end
         E_DIV: begin
            if (x.it == 7'h00) begin
               n.st   = x.ret;
               n.done = 1'b1;
            end else begin
               ge    = dr >= {1'b0, x.den};
               n.rem = {17'h0, ge ? dr - {1'b0, x.den} : dr};
               n.num = {x.num[62:0], ge};
               n.it  = x.it - 7'h01;
            end
         end
         E_SQRT: begin
            if (x.it == 7'h00) begin
               n.st   = x.ret;
               n.done = 1'b1;
            end else begin
               ge     = sr >= trial;
               n.rem  = ge ? sr - trial : sr;
               n.root = {x.root[30:0], ge};
               n.num  = {x.num[61:0], 2'b00};
               n.it   = x.it - 7'h01;
            end
         end
         E_PHS: begin
            unique case (x.k)
               3'h0: begin
                  if (x.done) begin
                     n.pavg = q48;
                     adv    = 1'b1;
                  end else begin
                     ld   = 1'b1;
                     lnum = {16'h0, pmag};
                     lden = {32'h0, x.ns};
                  end
               end
               3'h1: begin
                  if (x.done) begin
                     n.res[5'd6 + 5'(x.ph)] = q48;
                     adv = 1'b1;
                  end else begin
                     ld   = 1'b1;
                     lnum = {16'h0, pmag} * {48'h0, x.pcc};
                     lden = {32'h0, x.ns};
                  end
               end
               3'h2: begin
                  if (x.done) begin
                     n.qavg = q48;
                     adv    = 1'b1;
                  end else begin
                     ld   = 1'b1;
                     lnum = {16'h0, qmag};
                     lden = {32'h0, x.ns};
                  end
               end
               3'h3: begin
                  if (!x.apparent_method_select) begin
                     n.sap = {18'h0, vi[47:18]};
                     adv   = 1'b1;
                  end else if (x.done) begin
                     n.sap = {16'h0, x.root};
                     adv   = 1'b1;
                  end else begin
                     ldsq = 1'b1;
                     lnum = {16'h0, x.pavg} * {16'h0, x.pavg}
                          + {16'h0, x.qavg} * {16'h0, x.qavg};
                  end
               end
               3'h4: begin
                  n.res[5'd9 + 5'(x.ph)] = 48'({16'h0, x.sap} * {48'h0, x.pcc});
                  adv = 1'b1;
               end
               default: begin
                  if (x.done) begin
                     n.res[5'd12 + 5'(x.ph)] = q48;
                     adv = 1'b1;
                  end else begin
                     ld   = 1'b1;
                     lnum = {2'b00, x.pavg, 14'h0};
                     lden = x.sap;
                  end
               end
            endcase
            if (adv) begin
               n.done = 1'b0;
               n.k    = (x.k == 3'h5) ? 3'h0 : x.k + 3'h1;
               if (x.k == 3'h5) begin
                  if (x.ph == 2'h2) begin
                     n.st = E_MISC;
                  end else begin
                     n.ph = x.ph + 2'h1;
                  end
               end
            end
         end
         E_MISC: begin
            if (x.done) begin
               n.res[5'd15 + 5'(x.k)] = q48;
               n.done = 1'b0;
               n.k    = x.k + 3'h1;
               if (x.k == 3'h2) begin
                  n.st   = E_IDLE;
                  n.busy = 1'b0;
               end
            end else begin
               ld   = 1'b1;
               lden = {32'h0, x.ns};
               if (x.k == 3'h0) begin
                  lnum = {56'h0, x.cyc} * `MCIS_FREQ_K;
               end else begin
                  lnum = {48'h0, x.zc[x.k[0] ? 0 : 1]} * `MCIS_ANG_K;
               end
            end
         end
         default: n.st = E_IDLE;
      endcase

      if (ld || ldsq) begin
         n.num  = lnum;
         n.den  = lden;
         n.rem  = 66'h0;
         n.root = 32'h0;
         n.ret  = x.st;
         n.it   = ldsq ? `MCIS_SQRT_IT : `MCIS_DIV_IT;
         n.st   = ldsq ? E_SQRT : E_DIV;
      end

      // frame timebase and background integration
      tk     = x.tick == TICK_END;
      n.tick = tk ? 16'h0 : x.tick + 16'h1;
      if (tk) begin
         for (int p = 0; p < 3; p++) begin
            n.acc[p]     = x.acc[p] + prod[p];
            n.acc[p + 3] = x.acc[p + 3] + 64'($signed(afe.q[p]));
         end
         if (x.fcnt + 16'h1 >= x.ns) begin
            trig   = 1'b1;
            n.snap = n.acc;
            n.acc  = '0;
            n.fcnt = 16'h0;
         end else begin
            n.fcnt = x.fcnt + 16'h1;
         end
      end

      if (trig) begin
         n.rms = {afe.raw_rms_current, afe.raw_rms_voltage};
         n.zc  = afe.zc;
         for (int p = 0; p < 3; p++) begin
            acc_ok = (x.nl == 17'h0) ||
                     (afe.raw_rms_current[p] >= {7'h0, x.nl, 8'h0});
            if (x.dly == 8'h00 && acc_ok) begin
               n.eacc[p] = x.eacc[p] + n.snap[p];
            end
         end
         if (x.dly != 8'h00) begin
            n.dly = x.dly - 8'h01;
         end
         // an unfinished run is abandoned; its inputs are already gone
         ovr_set = x.busy;
         n.st    = E_RMS;
         n.k     = 3'h0;
         n.ph    = 2'h0;
         n.done  = 1'b0;
         n.busy  = 1'b1;
      end

      // apb slave, one wait state so read data comes from a flop
      off    = paddr - `MCIS_A_RES;
      word   = 64'(x.res[off[8:3]]);
      mapped = 1'b1;
      rd     = 32'h0;
      if (paddr >= `MCIS_A_RES && paddr < `MCIS_A_RES + 12'(8 * `MCIS_N_RES)) begin
         rd = paddr[2] ? word[63:32] : word[31:0];
      end else if (paddr >= `MCIS_A_EACC && paddr < `MCIS_A_EACC + 12'h018) begin
         off  = paddr - `MCIS_A_EACC;
         word = x.eacc[off[4:3]];
         rd   = paddr[2] ? word[63:32] : word[31:0];
      end else begin
         unique case (paddr)
            `MCIS_A_CTRL: rd = {29'h0, x.apparent_method_select, x.conn};
            `MCIS_A_CYC:  rd = {24'h0, x.cyc};
            `MCIS_A_NS:   rd = {16'h0, x.ns};
            `MCIS_A_DLY:  rd = {24'h0, x.dly};
            `MCIS_A_NL:   rd = {15'h0, x.nl};
            `MCIS_A_VCC:  rd = {16'h0, x.vcc};
            `MCIS_A_ICC:  rd = {16'h0, x.icc};
            `MCIS_A_PCC:  rd = {16'h0, x.pcc};
            `MCIS_A_STAT: rd = {29'h0, x.pen, x.ovr, x.busy};
            default:      mapped = 1'b0;
         endcase
      end
      n.pready = 1'b0;
      if (psel && penable && !x.pready) begin
         n.pready  = 1'b1;
         n.prdata  = pwrite ? 32'h0 : rd;
         n.pslverr = !mapped;
      end
      if (psel && penable && x.pready && pwrite && mapped) begin
         unique case (paddr)
            `MCIS_A_CTRL: begin
               n.conn   = pwdata[1:0];
               n.apparent_method_select = pwdata[2];
            end
            `MCIS_A_CYC:  n.cyc = pwdata[7:0];
            `MCIS_A_NS:   n.ns  = pwdata[15:0];
            `MCIS_A_DLY:  n.dly = pwdata[7:0];
            `MCIS_A_NL:   n.nl  = pwdata[16:0];
            `MCIS_A_VCC:  n.vcc = pwdata[15:0];
            `MCIS_A_ICC:  n.icc = pwdata[15:0];
            `MCIS_A_PCC:  n.pcc = pwdata[15:0];
            `MCIS_A_STAT: n.ovr = x.ovr & ~pwdata[1];
            default: ;
         endcase
      end
      if (ovr_set) begin
         n.ovr = 1'b1;
      end
      n.pen = n.dly == 8'h00;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x        <= '0;
         x.conn   <= `MCIS_CONN_RST;
         x.apparent_method_select <= `MCIS_APP_RST;
         x.cyc    <= `MCIS_CYC_RST;
         x.ns     <= `MCIS_NS_RST;
         x.dly    <= `MCIS_DLY_RST;
         x.vcc    <= `MCIS_CC_RST;
         x.icc    <= `MCIS_CC_RST;
         x.pcc    <= `MCIS_CC_RST;
         x.st     <= E_IDLE;
         x.ret    <= E_IDLE;
      end else begin
         x <= n;
      end
   end

   assign prdata       = x.prdata;
   assign pready       = x.pready;
   assign pslverr      = x.pslverr;
   assign pulse_enable = x.pen;
   assign post_busy    = x.busy;
endmodule
`default_nettype wire

// ===== bench/mcis_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcis_afe_model (
   output var mcis_pkg::mcis_afe_t afe
);
   import mcis_pkg::*;
   // steady levels keep every cycle integral an exact multiple of one frame product
   always_comb begin
      afe = '0;
      afe.v[0] = 16'h012C;
      afe.v[1] = 16'h01F4;
      afe.v[2] = 16'h0064;
      afe.i[0] = 16'h000A;
      afe.i[1] = 16'h0007;
      afe.i[2] = 16'h0009;
      afe.q[0] = 32'h00000FA0;
      afe.raw_rms_voltage[0] = 32'h02580000;
      afe.raw_rms_voltage[1] = 32'h00ABCDEF;
      afe.raw_rms_voltage[2] = 32'h00123456;
      afe.raw_rms_current[0] = 32'h00140000;
      afe.raw_rms_current[1] = 32'h00200000;
      afe.raw_rms_current[2] = 32'h00300000;
      afe.zc[0] = 16'h0020;
      afe.zc[1] = 16'h0040;
   end
endmodule
`default_nettype wire

// ===== bench/mcis_assertions.sv
`timescale 1ns/1ps
`include "mcis_params.svh"
`default_nettype none
module mcis_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        pulse_enable,
   input wire logic        post_busy
);
   logic [15:0] busy_cnt;
   logic        res_acc;
   logic        dly_wr;
   assign res_acc = pready && paddr >= `MCIS_A_RES && paddr < 12'h110;
   assign dly_wr  = pready && pwrite && paddr == `MCIS_A_DLY;
   // a trigger cuts off a runaway engine but keeps busy high, so the count runs on across restarts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) busy_cnt <= 16'h0000;
      else busy_cnt <= post_busy ? busy_cnt + 16'h0001 : 16'h0000;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy_next; psel && penable && !pready |=> pready; endproperty
   a_rdy_next: assert property (p_rdy_next) else $error("pready late");
   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
   property p_err_unmap; pready && paddr == 12'hFFC |-> pslverr; endproperty
   a_err_unmap: assert property (p_err_unmap) else $error("no error flag");
   property p_res_ok; res_acc |-> !pslverr; endproperty
   a_res_ok: assert property (p_res_ok) else $error("result refused");
   property p_hi48; res_acc && !pwrite && paddr[2] |-> prdata[31:16] == 16'h0000; endproperty
   a_hi48: assert property (p_hi48) else $error("result above 48 bits");
   property p_pe_reset; $rose(presetn) |-> !pulse_enable [*8]; endproperty
   a_pe_reset: assert property (p_pe_reset) else $error("pulse enabled at start");
   property p_pe_fall;
      $fell(pulse_enable) |-> $past(dly_wr, 1) || $past(dly_wr, 2) || $past(dly_wr, 3);
   endproperty
   a_pe_fall: assert property (p_pe_fall) else $error("pulse enable dropped");
   property p_busy_hold; $rose(post_busy) |=> post_busy [*4]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
   property p_busy_bound; busy_cnt < 16'h0BB8; endproperty
   a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
endmodule
bind mcis_top mcis_assertions u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pulse_enable(pulse_enable), .post_busy(post_busy));
`default_nettype wire

// ===== bench/mcis_tb_top.sv
`timescale 1ns/1ps
`include "mcis_params.svh"
`default_nettype none
module mcis_tb_top;
   import mcis_pkg::*;
   localparam int FCYC = 16;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pulse_enable;
   logic        post_busy;
   mcis_afe_t   afe;
   logic [31:0] rd;
   logic        err;
   logic [63:0] v0;
   logic [63:0] v1;
   int          n_fail = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          t_prev = 0;
   int          t_last = 0;
   logic [31:0] rst_v [8] = '{32'h0, 32'h1, 32'h3E, 32'h5, 32'h0, 32'h1, 32'h1, 32'h1};
   logic [31:0] conn_p [4] = '{32'hDAC, 32'h2BC, 32'hAF0, 32'h578};

   mcis_afe_model u_afe (.afe(afe));
   mcis_top #(.FRAME_CYC(FCYC)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .afe(afe), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pulse_enable(pulse_enable), .post_busy(post_busy));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd64(input logic [11:0] a, output logic [63:0] v);
      xfer(1'b0, a, 32'h0);
      v[31:0] = rd;
      xfer(1'b0, a + 12'h004, 32'h0);
      v[63:32] = rd;
   endtask

   task automatic res(input int k, input logic [63:0] exp, input string nm);
      rd64(`MCIS_A_RES + 12'(8 * k), v0);
      chk(nm, v0, exp);
   endtask

   // records the start of each processing cycle, then waits for its end
   task automatic proc_wait;
      while (post_busy !== 1'b1) @(posedge pclk);
      t_prev = t_last;
      t_last = cyc;
      while (post_busy !== 1'b0) @(posedge pclk);
   endtask

   task automatic energy_step(input logic [63:0] exp, input string nm);
      rd64(`MCIS_A_EACC, v0);
      proc_wait();
      rd64(`MCIS_A_EACC, v1);
      chk(nm, v1 - v0, exp);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int j = 0; j < 8; j++) begin
         xfer(1'b0, 12'(4 * j), 32'h0);
         chk("reset value", 64'(rd), 64'(rst_v[j]));
      end
      xfer(1'b0, 12'hFFC, 32'h0);
      chk("unmapped error", 64'(err), 64'h1);
      // longer cycle leaves the engine time to finish before the next trigger
      xfer(1'b1, `MCIS_A_NS, 32'h80);
      xfer(1'b1, `MCIS_A_PCC, 32'h3);
      xfer(1'b1, `MCIS_A_VCC, 32'h1234);
      xfer(1'b1, `MCIS_A_ICC, 32'h0101);
      for (int t = 1; t <= 5; t++) begin
         proc_wait();
         if (t > 1) chk("trigger period", 64'(t_last - t_prev), 64'(128 * FCYC));
         chk("pulse enable", 64'(pulse_enable), 64'(t == 5));
         if (t == 4) begin
            rd64(`MCIS_A_EACC, v0);
            chk("energy held", v0, 64'h0);
         end
      end
      res(0, 64'(32'h02580000) * 64'h1234, "volts a");
      res(3, 64'(32'h00140000) * 64'h0101, "amps a");
      res(6, 64'h2328, "power a");
      res(8, 64'h0A8C, "power c");
      res(12, 64'h4000, "pf product");
      res(15, `MCIS_FREQ_K / 64'h80, "frequency");
      res(16, `MCIS_ANG_K * 64'h20 / 64'h80, "angle ab");
      res(17, `MCIS_ANG_K * 64'h40 / 64'h80, "angle ac");
      energy_step(64'h5DC00, "energy step");
      xfer(1'b1, `MCIS_A_NL, 32'h10000);
      energy_step(64'h0, "creep step");
      xfer(1'b1, `MCIS_A_NL, 32'h0);
      xfer(1'b1, `MCIS_A_DLY, 32'h2);
      repeat (2) @(posedge pclk);
      chk("delay restart", 64'(pulse_enable), 64'h0);
      energy_step(64'h0, "delay step");
      proc_wait();
      chk("delay done", 64'(pulse_enable), 64'h1);
      for (int c = 0; c < 4; c++) begin
         xfer(1'b1, `MCIS_A_CTRL, 32'(c));
         proc_wait();
         proc_wait();
         res(7, 64'(conn_p[c]) * 64'h3, "power b");
      end
      xfer(1'b1, `MCIS_A_CTRL, 32'h4);
      proc_wait();
      proc_wait();
      res(12, 64'h2666, "pf squares");
      xfer(1'b0, `MCIS_A_STAT, 32'h0);
      chk("overrun", 64'(rd[1]), 64'h0);
      // a short cycle outruns the engine on purpose, so a trigger lands while busy
      xfer(1'b1, `MCIS_A_NS, 32'h20);
      repeat (1200) @(posedge pclk);
      xfer(1'b0, `MCIS_A_STAT, 32'h0);
      chk("overrun set", 64'(rd[1:0]), 64'h3);
      xfer(1'b1, `MCIS_A_NS, 32'h80);
      xfer(1'b1, `MCIS_A_STAT, 32'h2);
      xfer(1'b0, `MCIS_A_STAT, 32'h0);
      chk("overrun clear", 64'(rd[1]), 64'h0);
      end_sim();
   end
endmodule
`default_nettype wire
